// ==== rtl/dpram_port_ctrl.v ====
// controller that drives one port of the shared dual-port memory
// How it works
// - busy low: hold operation until released
// - delay slave write past arbitration time
// - hold write pulse beyond busy release; here busy mid-strobe drops it, and it is strobed again after release
// - wide systems: one master arbiter only
`timescale 1ns/1ns
`default_nettype none
`include "dpram_port_map.vh"
module dpram_port_ctrl #(
  parameter AW = `ADDR_W,
  parameter DW = `DATA_W,
  parameter MBOX_ADDR = `MBOX_LEFT_ADDR,
  parameter PEER_MBOX_ADDR = `MBOX_RIGHT_ADDR
) (
  input  wire          core_clk,
  input  wire          rstn,
  input  wire          req_valid,
  input  wire          req_write,
  input  wire [AW-1:0] req_addr,
  input  wire [DW-1:0] req_wdata,
  input  wire [1:0]    req_byte_en,
  output reg           req_ready,
  output reg           rsp_valid,
  output reg  [DW-1:0] rsp_rdata,
  output reg           mbox_irq,
  output reg           port_busy,
  output reg           chip_sel_n,
  output reg           rd_wr_n,
  output reg           out_en_n,
  output reg  [AW-1:0] addr,
  output reg  [DW-1:0] data_out,
  output reg  [DW-1:0] data_oe,
  input  wire [DW-1:0] data_in,
  output reg           upper_byte_sel_n,
  output reg           lower_byte_sel_n,
  input  wire          busy_n,
  input  wire          irq_n
);
  // least times round up; arbitration and hold to at least one cycle
  localparam [31:0] SETUP_CYC  = (`SETUP_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [31:0] ARB_CYC_R  = (`ARB_MAX_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [31:0] ARB_CYC    = (ARB_CYC_R < 1) ? 1 : ARB_CYC_R;
  localparam [31:0] HOLD_CYC_R = (`WR_HOLD_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [31:0] HOLD_CYC   = (HOLD_CYC_R < 1) ? 1 : HOLD_CYC_R;
  localparam [31:0] ACC_CYC_R  = (`ACCESS_NS + `CLK_NS - 1) / `CLK_NS;
  // pins pass the synchroniser first, so both waits allow for it:
  // no strobe may start before busy is seen settled
  localparam [31:0] ARB_TOT    = ARB_CYC + `SYNC_LAT;
  localparam [31:0] ACC_TOT    = ACC_CYC_R + `SYNC_LAT;
  // counters run down to zero; cut on purpose to their width
  localparam [3:0]  CNT_ARB    = ARB_TOT[3:0];
  localparam [3:0]  CNT_HOLD   = HOLD_CYC[3:0];
  localparam [3:0]  CNT_ACC    = ACC_TOT[3:0];
  localparam [3:0]  CNT_SET    = SETUP_CYC[3:0];

  // one-hot state codes
  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_SETUP = 6'h02;
  localparam [5:0] ST_ARB   = 6'h04;
  localparam [5:0] ST_XFER  = 6'h08;
  localparam [5:0] ST_WAIT  = 6'h10;
  localparam [5:0] ST_DONE  = 6'h20;

  ////////////////////////////////////////////////////////////////////////
  wire [DW-1:0] data_sync;
  wire          busy_sync;
  wire          irq_sync;
  pin_sync3 #(.W(DW), .INIT({DW{1'b0}})) u_data_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   (data_in),
    .sync_out (data_sync)
  );
  // busy is only ever read here: the one arbiter sits in the memory
  pin_sync3 #(.W(2), .INIT(2'h3)) u_flag_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   ({busy_n, irq_n}),
    .sync_out ({busy_sync, irq_sync})
  );

  ////////////////////////////////////////////////////////////////////////
  // one access at a time: idle, setup, arbitrate, strobe, hold.
  // busy before the strobe parks the access in wait with all pins
  // held; busy during the strobe drops it and starts over
  reg [5:0]    state_reg;
  reg [3:0]    cnt_reg;
  reg          wr_reg;
  reg [1:0]    be_reg;
  reg [DW-1:0] wdata_reg;
  // unselected lanes neither drive nor return data
  wire [DW-1:0] lane_mask = {{(DW/2){be_reg[1]}}, {(DW/2){be_reg[0]}}};

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg        <= ST_IDLE;
      cnt_reg          <= 4'h0;
      wr_reg           <= 1'b0;
      be_reg           <= 2'h0;
      wdata_reg        <= {DW{1'b0}};
      req_ready        <= 1'b0;
      rsp_valid        <= 1'b0;
      rsp_rdata        <= {DW{1'b0}};
      mbox_irq         <= 1'b0;
      port_busy        <= 1'b0;
      chip_sel_n       <= 1'b1;
      rd_wr_n          <= 1'b1;
      out_en_n         <= 1'b1;
      addr             <= {AW{1'b0}};
      data_out         <= {DW{1'b0}};
      data_oe          <= {DW{1'b0}};
      upper_byte_sel_n <= 1'b1;
      lower_byte_sel_n <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      mbox_irq  <= ~irq_sync;
      port_busy <= ~busy_sync;
      case (state_reg)
        ST_IDLE: begin
          chip_sel_n <= 1'b1;
          // ready only while idle: one access outstanding
          req_ready  <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready        <= 1'b0;
            wr_reg           <= req_write;
            be_reg           <= req_byte_en;
            wdata_reg        <= req_wdata;
            addr             <= req_addr;
            upper_byte_sel_n <= ~req_byte_en[1];
            lower_byte_sel_n <= ~req_byte_en[0];
            cnt_reg          <= CNT_SET;
            state_reg        <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // address settles before select falls, so arbitration
          // is decided on select order
          if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else begin
            chip_sel_n <= 1'b0;
            cnt_reg    <= CNT_ARB;
            state_reg  <= ST_ARB;
          end
        end
        ST_ARB: begin
          // no strobe until busy has settled past arbitration
          if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else if (!busy_sync) begin
            state_reg <= ST_WAIT;
          end else begin
            rd_wr_n   <= ~wr_reg;
            out_en_n  <= wr_reg;
            data_out  <= wdata_reg & lane_mask;
            data_oe   <= wr_reg ? lane_mask : {DW{1'b0}};
            cnt_reg   <= CNT_ACC;
            state_reg <= ST_XFER;
          end
        end
        ST_WAIT: begin
          // address, data and select held unchanged while inhibited
          if (busy_sync) begin
            cnt_reg   <= CNT_ARB;
            state_reg <= ST_ARB;
          end
        end
        ST_XFER: begin
          if (!busy_sync) begin
            // lost mid-cycle: drop strobe, wait, then re-arbitrate and strobe again
            rd_wr_n   <= 1'b1;
            out_en_n  <= 1'b1;
            data_oe   <= {DW{1'b0}};
            state_reg <= ST_WAIT;
          end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else begin
            // read data has cleared the synchroniser by now
            rsp_rdata <= data_sync & lane_mask;
            rd_wr_n   <= 1'b1;
            out_en_n  <= 1'b1;
            cnt_reg   <= CNT_HOLD;
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          // data held past strobe release for write hold
          if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else begin
            data_oe    <= {DW{1'b0}};
            chip_sel_n <= 1'b1;
            rsp_valid  <= 1'b1;
            state_reg  <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== rtl/dpram_port_map.vh ====
// constants for the shared-memory port controller
`ifndef DPRAM_PORT_MAP_VH
`define DPRAM_PORT_MAP_VH
`define ADDR_W          12
`define DATA_W          16
`define MBOX_LEFT_ADDR  12'hffe
`define MBOX_RIGHT_ADDR 12'hfff
`define ARB_MAX_NS      5
`define WR_HOLD_NS      5
`define SETUP_NS        40
`define ACCESS_NS       55
`define CLK_NS          40
`define SYNC_LAT        3
`endif

// ==== rtl/pin_sync3.v ====
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input  wire         core_clk,
  input  wire         rstn,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  integer i;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg   <= INIT;
      s2_reg   <= INIT;
      s3_reg   <= INIT;
      sync_out <= INIT;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // a bit changes only once two stages agree
      for (i = 0; i < W; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i]) begin
          sync_out[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/dpram_far_model.sv ====
// behavioural shared memory as seen from the controlled port
`timescale 1ns/1ns
`default_nettype none
module dpram_far_model #(
  parameter [11:0] MBOX = 12'hffe
) (
  input  wire logic        chip_sel_n,
  input  wire logic        rd_wr_n,
  input  wire logic        out_en_n,
  input  wire logic [11:0] addr,
  input  wire logic [15:0] data_out,
  input  wire logic [15:0] data_oe,
  input  wire logic        upper_byte_sel_n,
  input  wire logic        lower_byte_sel_n,
  input  wire logic        peer_hold,
  input  wire logic [11:0] peer_addr,
  input  wire logic        peer_mbox_wr,
  output logic      [15:0] data_in,
  output logic             busy_n,
  output logic             irq_n
);
  logic [15:0] mem [0:4095];
  logic [15:0] last;
  wire logic   drive = !chip_sel_n && rd_wr_n && !out_en_n;
  initial begin
    last = 16'h0;
    irq_n = 1'h1;
  end
  // peer already on the word wins; no match means no arbitration
  assign busy_n = !(peer_hold && !chip_sel_n
                    && addr == peer_addr);
  // released bus shows the inverse so a stale value cannot pass
  assign data_in = drive ? mem[addr] : ~last;
  always @(posedge out_en_n) last <= mem[addr];
  always @(posedge rd_wr_n) begin
    if (!chip_sel_n && busy_n) begin
      // undriven bits land inverted, so a missing enable shows
      if (!upper_byte_sel_n)
        mem[addr][15:8] <= data_out[15:8] ^ ~data_oe[15:8];
      if (!lower_byte_sel_n)
        mem[addr][7:0] <= data_out[7:0] ^ ~data_oe[7:0];
    end
  end
  always @(posedge peer_mbox_wr or negedge out_en_n) begin
    if (peer_mbox_wr) irq_n <= 1'h0;
    else if (!chip_sel_n && addr == MBOX) irq_n <= 1'h1;
  end
endmodule
`default_nettype wire

// ==== test/dpram_port_ctrl_bench.sv ====
// self-checking bench for the port controller with a memory model
`timescale 1ns/1ns
`default_nettype none
module dpram_port_ctrl_bench;
  logic        core_clk, rstn, req_valid, req_write, req_ready, rsp_valid;
  logic        mbox_irq, port_busy, chip_sel_n, rd_wr_n, out_en_n;
  logic        upper_byte_sel_n, lower_byte_sel_n, busy_n, irq_n;
  logic        peer_hold, peer_mbox_wr;
  logic [1:0]  req_byte_en;
  logic [11:0] req_addr, addr, peer_addr;
  logic [15:0] req_wdata, rsp_rdata, data_out, data_oe, data_in;
  int          fails, compares, n;
  dpram_port_ctrl i_dut (.*);
  dpram_far_model i_mem (.*);
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(logic w, logic [11:0] a, logic [15:0] d, logic [1:0] b);
    @(posedge core_clk);
    req_valid <= 1'h1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_byte_en <= b;
    do @(posedge core_clk); while (req_ready !== 1'h1);
    req_valid <= 1'h0;
    n = 0;
    while (rsp_valid !== 1'h1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    check("response", 16'h1, {15'h0, n < 200});
  endtask
  task automatic t_bytes;
    xfer(1'h1, 12'h000, 16'h1234, 2'h3);
    xfer(1'h1, 12'h000, 16'habcd, 2'h2);
    xfer(1'h0, 12'h000, 16'h0, 2'h3);
    check("merged word", 16'hab34, rsp_rdata);
    xfer(1'h0, 12'h000, 16'h0, 2'h1);
    check("low lane", 16'h0034, rsp_rdata);
    xfer(1'h1, 12'hfff, 16'h5a5a, 2'h3);
    xfer(1'h0, 12'hfff, 16'h0, 2'h3);
    check("top word", 16'h5a5a, rsp_rdata);
    $display("t_bytes done");
  endtask
  task automatic t_busy;
    peer_addr <= 12'h010;
    peer_hold <= 1'h1;
    xfer(1'h1, 12'h011, 16'h0011, 2'h3);
    check("free word fast", 16'h1, {15'h0, n < 20});
    fork
      xfer(1'h1, 12'h010, 16'hbeef, 2'h3);
      begin
        repeat (40) @(posedge core_clk);
        check("busy seen", 16'h1, {15'h0, port_busy});
        peer_hold <= 1'h0;
      end
    join
    check("held write late", 16'h1, {15'h0, n > 30});
    xfer(1'h0, 12'h010, 16'h0, 2'h3);
    check("held write data", 16'hbeef, rsp_rdata);
    $display("t_busy done");
  endtask
  task automatic t_irq;
    peer_mbox_wr <= 1'h1;
    @(posedge core_clk);
    peer_mbox_wr <= 1'h0;
    repeat (5) @(posedge core_clk);
    check("irq raised", 16'h1, {15'h0, mbox_irq});
    xfer(1'h0, 12'hffe, 16'h0, 2'h3);
    repeat (5) @(posedge core_clk);
    check("irq cleared", 16'h0, {15'h0, mbox_irq});
    $display("t_irq done");
  endtask
  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {rstn, req_valid, req_write, peer_hold, peer_mbox_wr} = 5'h0;
    {req_byte_en, req_addr, peer_addr, req_wdata} = 42'h0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'h1;
    t_bytes;
    t_busy;
    t_irq;
    give_verdict;
  end
  // the three tests need well under a thousand cycles
  initial begin
    #400000;
    fails++;
    give_verdict;
  end
endmodule
`default_nettype wire

// ==== test/dpram_port_sva.sv ====
// assertions on the pins of the port controller
`timescale 1ns/1ns
`default_nettype none
module dpram_port_sva (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [1:0]  req_byte_en,
  input wire logic        rsp_valid,
  input wire logic        mbox_irq,
  input wire logic        port_busy,
  input wire logic        chip_sel_n,
  input wire logic        rd_wr_n,
  input wire logic        out_en_n,
  input wire logic [15:0] data_oe,
  input wire logic        upper_byte_sel_n,
  input wire logic        lower_byte_sel_n,
  input wire logic        irq_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_sel; ##[1:3] !chip_sel_n; endsequence
  property p_take_sel; s_take |-> s_sel; endproperty
  property p_idle; req_ready |-> chip_sel_n && rd_wr_n && out_en_n; endproperty
  property p_read_oe; !out_en_n |-> rd_wr_n && data_oe == 16'h0; endproperty
  property p_wr_sel; !rd_wr_n |-> !chip_sel_n && out_en_n; endproperty
  property p_bytes;
    s_take |=> upper_byte_sel_n == !$past(req_byte_en[1])
      && lower_byte_sel_n == !$past(req_byte_en[0]);
  endproperty
  // one cycle of slack for the strobe to drop
  property p_busy_stop; port_busy [*2] |-> rd_wr_n && out_en_n; endproperty
  property p_hold; $rose(rd_wr_n) |-> !chip_sel_n; endproperty
  property p_rsp; rsp_valid |=> !rsp_valid; endproperty
  // pin passes three flops, the agreement flop and the output flop
  property p_irq_up; $fell(irq_n) |-> ##[4:6] mbox_irq; endproperty
  property p_irq_dn; $rose(irq_n) |-> ##[4:6] !mbox_irq; endproperty
  a_take_sel: assert property (p_take_sel) else $error("no select");
  a_idle: assert property (p_idle) else $error("pins active in idle");
  a_read_oe: assert property (p_read_oe) else $error("oe clash");
  a_wr_sel: assert property (p_wr_sel) else $error("bad write strobe");
  a_bytes: assert property (p_bytes) else $error("byte select wrong");
  a_busy_stop: assert property (p_busy_stop) else $error("busy ignored");
  a_hold: assert property (p_hold) else $error("select dropped early");
  a_rsp: assert property (p_rsp) else $error("response too long");
  a_irq_up: assert property (p_irq_up) else $error("irq not raised");
  a_irq_dn: assert property (p_irq_dn) else $error("irq not cleared");
endmodule
bind dpram_port_ctrl dpram_port_sva i_sva (
  .core_clk         (core_clk),
  .rstn             (rstn),
  .req_valid        (req_valid),
  .req_ready        (req_ready),
  .req_byte_en      (req_byte_en),
  .rsp_valid        (rsp_valid),
  .mbox_irq         (mbox_irq),
  .port_busy        (port_busy),
  .chip_sel_n       (chip_sel_n),
  .rd_wr_n          (rd_wr_n),
  .out_en_n         (out_en_n),
  .data_oe          (data_oe),
  .upper_byte_sel_n (upper_byte_sel_n),
  .lower_byte_sel_n (lower_byte_sel_n),
  .irq_n            (irq_n)
);
`default_nettype wire
